// ### temp_sensor_defs.svh
// Purpose: shared constants of the temperature sensor serial slave port
// Assumes: included by bare name from every design file that needs it
// Notes:   times are in ns; filter cycle counts are derived where they are used
`ifndef TEMP_SENSOR_DEFS_SVH
`define TEMP_SENSOR_DEFS_SVH

// ============================================================
// address byte and pointer
`define HS_CODE_TOP      5'h01
`define PTR_TEMP         8'h00
`define ADDR_LOW_W       3

// ============================================================
// resolution and result format
`define RES_DEFAULT      2'h0
`define RES_MAX          2'h3
`define TEMP_FRAC_W      4

// ============================================================
// timing
`define LINK_CLK_NS      30
`define FILT_STD_NS      90
`define FILT_HS_NS       30
`define CONV_BASE_CYCLES 1024

`endif

// ### temp_sensor_pkg.sv
// Purpose: types shared by the serial slave port files
// Assumes: nothing beyond the defines header
// Notes:   state codes are left to the tools
package temp_sensor_pkg;

	// ============================================================
	// link state machine
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_RX_BIT,
		ST_ACK_SETUP,
		ST_ACK_SLOT,
		ST_TX_BIT,
		ST_TX_ACK
	} link_state_t;

	typedef logic [1:0] res_sel_t;

endpackage

// ### line_filter.sv
// Purpose: synchronise one bus line and suppress spikes on it
// Assumes: pin_i is asynchronous to clk_i
// Notes:   the level only follows after a run of equal samples
`timescale 1ns/10ps
module line_filter #(
	parameter int STD_CYC = 3,
	parameter int HS_CYC  = 1
)(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	input  wire logic hs_i,
	output logic      level_o
);
	logic       meta_reg;
	logic       sync_reg;
	logic [3:0] run_reg;
	logic [3:0] limit;

	// ============================================================
	// two-flop synchroniser
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
		end
		else
		begin
			meta_reg <= pin_i;
			sync_reg <= meta_reg;
		end
	end

	// ============================================================
	// spike filter, shorter in high-speed operation
	assign limit = hs_i ? 4'(HS_CYC) : 4'(STD_CYC);

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			run_reg <= 4'h0;
			level_o <= 1'b1;
		end
		else if (sync_reg == level_o)
			run_reg <= 4'h0;
		else if (run_reg + 4'h1 >= limit)
		begin
			run_reg <= 4'h0;
			level_o <= sync_reg;
		end
		else
			run_reg <= run_reg + 4'h1;
	end
endmodule

// ### temp_converter.sv
// Purpose: pace conversions and format the result word
// Assumes: sample_i is the settled code of the sensor front end
// Notes:   result is left justified, 1/16 degree per lsb
`timescale 1ns/10ps
`include "temp_sensor_defs.svh"
module temp_converter
	import temp_sensor_pkg::*;
#(
	parameter int BASE_CYC = `CONV_BASE_CYCLES
)(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire res_sel_t    res_i,
	input  wire logic [11:0] sample_i,
	output logic      [15:0] result_o,
	output logic             done_o
);
	logic [15:0] cnt_reg;
	logic [15:0] limit;
	logic [11:0] mask;

	// each extra bit doubles the conversion time
	assign limit = 16'(BASE_CYC << res_i) - 16'h0001;            // RULE17
	assign mask  = 12'hFFF << (2'h3 - res_i);                     // RULE15

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cnt_reg <= 16'h0000;
		else if (cnt_reg >= limit)
			cnt_reg <= 16'h0000;
		else
			cnt_reg <= cnt_reg + 16'h0001;
	end

	// two's complement, spans -128 to +127.9375 degrees
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			result_o <= 16'h0000;
			done_o   <= 1'b0;
		end
		else
		begin
			done_o <= (cnt_reg >= limit);                              // RULE14
			if (cnt_reg >= limit)
				result_o <= {sample_i & mask, `TEMP_FRAC_W'(0)};          // RULE18
		end
	end
endmodule

// ### temp_sensor_serial_slave_port.sv
// Purpose: two-wire slave port and resolution control of a temperature sensor
// Assumes: link_clk_i oversamples the bus lines; bus pull-ups are outside
// Notes:   only the temperature pointer exists; it cannot be written
// How it works
// RULE1: ack drives data low whole ninth clock
// RULE2: master releases data, clocks ninth bit
// RULE3: master nack on read makes us release
// RULE4: nack writes to read-only temperature
// RULE5: address is type id plus straps
// RULE6: address bits 7..1, bit 0 direction
// RULE7: master sends start then address byte
// RULE8: ack matching address, else nack, idle
// RULE9: strapless variant uses build-time low bits
// RULE10: master code 00001xxx is never acknowledged
// RULE11: master code switches filters to high speed
// RULE12: high speed held across restarts, stop ends
// RULE13: master prefers restarts in high speed
// RULE14: continuous conversion updates result register
// RULE15: resolution 9 to 12 bits, two-bit field
// RULE16: reset selects nine-bit resolution
// RULE17: conversion time grows with resolution
// RULE18: result spans -128 to +127 degrees
// RULE19: field 0,1,2,3 gives 9,10,11,12 bits
// RULE20: sample on rise, drive on fall, msb first
// RULE21: start is data fall while clock high
// RULE22: stop is data rise while clock high
`timescale 1ns/10ps
`include "temp_sensor_defs.svh"
module temp_sensor_serial_slave_port
	import temp_sensor_pkg::*;
#(
	parameter int         CONV_BASE_CYC = `CONV_BASE_CYCLES,
	parameter bit         HAS_STRAPS    = 1'b1,
	parameter logic [2:0] FIXED_LOW     = 3'h0,
	parameter logic [3:0] TYPE_ID       = 4'hA  // value arbitrary
)(
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        link_clk_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic        addr_strap_bit2_i,
	input  wire logic        addr_strap_bit1_i,
	input  wire logic        addr_strap_bit0_i,
	input  wire logic        resolution_select_hi_i,
	input  wire logic        resolution_select_lo_i,
	input  wire logic        res_load_i,
	input  wire logic [11:0] sensor_code_i,
	output logic      [15:0] temp_result_o,
	output logic             conv_done_o,
	output logic      [1:0]  resolution_o,
	output logic             hs_mode_o
);
	localparam int STD_CYC = (`FILT_STD_NS / `LINK_CLK_NS < 1) ? 1
		: `FILT_STD_NS / `LINK_CLK_NS;
	localparam int HS_CYC = (`FILT_HS_NS / `LINK_CLK_NS < 1) ? 1
		: `FILT_HS_NS / `LINK_CLK_NS;

	function automatic logic is_hs_code(input logic [7:0] b);
		is_hs_code = (b[7:3] == `HS_CODE_TOP);
	endfunction

	// ============================================================
	// core domain: resolution and conversion
	res_sel_t res_reg;
	logic     temp_tgl_reg;
	logic     hs_meta_reg;

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			res_reg <= `RES_DEFAULT;                                   // RULE16
		else if (res_load_i)
			res_reg <= {resolution_select_hi_i, resolution_select_lo_i}; // RULE19
	end

	assign resolution_o = res_reg;

	temp_converter #(
		.BASE_CYC (CONV_BASE_CYC)
	) u_conv (
		.clk_i    (core_clk_i),
		.rst_i    (rst_i),
		.res_i    (res_reg),
		.sample_i (sensor_code_i),
		.result_o (temp_result_o),
		.done_o   (conv_done_o)
	);

	// result stays put for a whole conversion, far longer than the crossing
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			temp_tgl_reg <= 1'b0;
		else
			temp_tgl_reg <= temp_tgl_reg ^ conv_done_o;               // RULE14
	end

	// ============================================================
	// link domain reset and line conditioning
	logic       link_rst_meta_reg;
	logic       link_rst;
	logic       hs_mode_reg;
	logic       scl_f;
	logic       sda_f;
	logic       scl_prev_reg;
	logic       sda_prev_reg;
	logic [2:0] strap_meta_reg;
	logic [2:0] strap_sync_reg;
	logic [6:0] own_addr;

	always_ff @(posedge link_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			link_rst_meta_reg <= 1'b1;
			link_rst          <= 1'b1;
		end
		else
		begin
			link_rst_meta_reg <= 1'b0;
			link_rst          <= link_rst_meta_reg;
		end
	end

	line_filter #(.STD_CYC(STD_CYC), .HS_CYC(HS_CYC)) u_scl_filt (
		.clk_i   (link_clk_i),
		.rst_i   (link_rst),
		.pin_i   (scl_i),
		.hs_i    (hs_mode_reg),
		.level_o (scl_f)
	);

	line_filter #(.STD_CYC(STD_CYC), .HS_CYC(HS_CYC)) u_sda_filt (
		.clk_i   (link_clk_i),
		.rst_i   (link_rst),
		.pin_i   (sda_i),
		.hs_i    (hs_mode_reg),
		.level_o (sda_f)
	);

	always_ff @(posedge link_clk_i or posedge link_rst)
	begin
		if (link_rst)
		begin
			scl_prev_reg   <= 1'b1;
			sda_prev_reg   <= 1'b1;
			strap_meta_reg <= 3'h0;
			strap_sync_reg <= 3'h0;
		end
		else
		begin
			scl_prev_reg   <= scl_f;
			sda_prev_reg   <= sda_f;
			strap_meta_reg <= {addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i};
			strap_sync_reg <= strap_meta_reg;
		end
	end

	assign own_addr = {TYPE_ID, HAS_STRAPS ? strap_sync_reg : FIXED_LOW}; // RULE5 RULE9

	// ============================================================
	// bus events
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;

	assign scl_rise  = scl_f & ~scl_prev_reg;                         // RULE20
	assign scl_fall  = ~scl_f & scl_prev_reg;
	assign start_det = scl_f & scl_prev_reg & sda_prev_reg & ~sda_f; // RULE21
	assign stop_det  = scl_f & scl_prev_reg & ~sda_prev_reg & sda_f; // RULE22

	// ============================================================
	// temperature word into the link domain
	logic        tgl_meta_reg;
	logic        tgl_sync_reg;
	logic        tgl_prev_reg;
	logic [15:0] temp_link_reg;

	always_ff @(posedge link_clk_i or posedge link_rst)
	begin
		if (link_rst)
		begin
			tgl_meta_reg  <= 1'b0;
			tgl_sync_reg  <= 1'b0;
			tgl_prev_reg  <= 1'b0;
			temp_link_reg <= 16'h0000;
		end
		else
		begin
			tgl_meta_reg <= temp_tgl_reg;
			tgl_sync_reg <= tgl_meta_reg;
			tgl_prev_reg <= tgl_sync_reg;
			if (tgl_sync_reg ^ tgl_prev_reg)
				temp_link_reg <= temp_result_o;                        // RULE14
		end
	end

	// ============================================================
	// byte engine
	link_state_t st_reg;
	logic [3:0]  bit_cnt_reg;
	logic [7:0]  shift_reg;
	logic [7:0]  rx_byte;
	logic [7:0]  tx_next;
	logic [15:0] tx_snap_reg;
	logic        first_reg;
	logic        ptr_ph_reg;
	logic        rw_reg;
	logic        ack_pend_reg;
	logic        ack_next;
	logic        ack_seen_reg;
	logic        mack_reg;
	logic        byte_hi_reg;

	assign rx_byte = {shift_reg[6:0], sda_f};
	assign tx_next = byte_hi_reg ? tx_snap_reg[15:8] : tx_snap_reg[7:0];

	always_comb
	begin
		ack_next = 1'b0;
		if (first_reg)
			ack_next = !is_hs_code(rx_byte) && (rx_byte[7:1] == own_addr); // RULE8 RULE10
		else if (ptr_ph_reg)
			ack_next = (rx_byte == `PTR_TEMP);
	end

	always_ff @(posedge link_clk_i or posedge link_rst)
	begin
		if (link_rst)
		begin
			st_reg       <= ST_IDLE;
			bit_cnt_reg  <= 4'h0;
			shift_reg    <= 8'h00;
			tx_snap_reg  <= 16'h0000;
			first_reg    <= 1'b0;
			ptr_ph_reg   <= 1'b0;
			rw_reg       <= 1'b0;
			ack_pend_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
			mack_reg     <= 1'b0;
			byte_hi_reg  <= 1'b0;
			sda_oe_o     <= 1'b0;
		end
		else if (stop_det)
		begin
			st_reg   <= ST_IDLE;                                       // RULE22
			sda_oe_o <= 1'b0;
		end
		else if (start_det)
		begin
			st_reg      <= ST_RX_BIT;                                   // RULE21
			bit_cnt_reg <= 4'h0;
			first_reg   <= 1'b1;
			ptr_ph_reg  <= 1'b0;
			sda_oe_o    <= 1'b0;
		end
		else
		begin
			case (st_reg)
				ST_RX_BIT:
					if (scl_rise)
					begin
						shift_reg   <= rx_byte;                              // RULE20
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == 4'h7)
						begin
							st_reg       <= ST_ACK_SETUP;
							ack_pend_reg <= ack_next;                          // RULE4 RULE8
							if (first_reg)
								rw_reg <= sda_f;                                 // RULE6
						end
					end
				ST_ACK_SETUP:
					if (scl_fall)
					begin
						sda_oe_o     <= ack_pend_reg;                         // RULE1
						ack_seen_reg <= 1'b0;
						st_reg       <= ST_ACK_SLOT;
					end
				ST_ACK_SLOT:
				begin
					if (scl_rise)
						ack_seen_reg <= 1'b1;
					if (scl_fall && ack_seen_reg)
					begin
						bit_cnt_reg <= 4'h0;
						first_reg   <= 1'b0;
						if (!ack_pend_reg)
						begin
							sda_oe_o <= 1'b0;
							st_reg   <= ST_IDLE;                               // RULE8
						end
						else if (first_reg && rw_reg)
						begin
							tx_snap_reg <= temp_link_reg;
							shift_reg   <= temp_link_reg[15:8];
							sda_oe_o    <= ~temp_link_reg[15];
							byte_hi_reg <= 1'b0;
							st_reg      <= ST_TX_BIT;
						end
						else
						begin
							sda_oe_o   <= 1'b0;
							ptr_ph_reg <= first_reg;
							st_reg     <= ST_RX_BIT;
						end
					end
				end
				ST_TX_BIT:
					if (scl_rise)
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					else if (scl_fall && bit_cnt_reg == 4'h8)
					begin
						sda_oe_o     <= 1'b0;
						ack_seen_reg <= 1'b0;
						st_reg       <= ST_TX_ACK;
					end
					else if (scl_fall)
					begin
						shift_reg <= {shift_reg[6:0], 1'b0};                 // RULE20
						sda_oe_o  <= ~shift_reg[6];
					end
				ST_TX_ACK:
				begin
					if (scl_rise)
					begin
						ack_seen_reg <= 1'b1;
						mack_reg     <= ~sda_f;
					end
					if (scl_fall && ack_seen_reg && mack_reg)
					begin
						shift_reg   <= tx_next;
						sda_oe_o    <= ~tx_next[7];
						byte_hi_reg <= ~byte_hi_reg;
						bit_cnt_reg <= 4'h0;
						st_reg      <= ST_TX_BIT;
					end
					else if (scl_fall && ack_seen_reg)
					begin
						sda_oe_o <= 1'b0;                                    // RULE3
						st_reg   <= ST_IDLE;
					end
				end
				default:
					st_reg <= ST_IDLE;
			endcase
		end
	end

	// open-drain: the pad only ever pulls low
	always_ff @(posedge link_clk_i or posedge link_rst)
	begin
		if (link_rst)
			sda_o <= 1'b0;
		else
			sda_o <= 1'b0;
	end

	// ============================================================
	// high-speed filter mode
	always_ff @(posedge link_clk_i or posedge link_rst)
	begin
		if (link_rst)
			hs_mode_reg <= 1'b0;
		else if (stop_det)
			hs_mode_reg <= 1'b0;                                        // RULE12
		else if (st_reg == ST_RX_BIT && scl_rise && bit_cnt_reg == 4'h7
			&& first_reg && is_hs_code(rx_byte))
			hs_mode_reg <= 1'b1;                                        // RULE11
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			hs_meta_reg <= 1'b0;
			hs_mode_o   <= 1'b0;
		end
		else
		begin
			hs_meta_reg <= hs_mode_reg;
			hs_mode_o   <= hs_meta_reg;
		end
	end

	// ============================================================
	// checks
	sequence addr_last_bit_s;
		st_reg == ST_RX_BIT && scl_rise && bit_cnt_reg == 4'h7 && first_reg;
	endsequence

	ack_hold_a: assert property (@(posedge link_clk_i) disable iff (link_rst) // RULE1
		(st_reg == ST_ACK_SLOT && ack_pend_reg) |-> sda_oe_o)
		else $error("ack not held low");
	read_nack_a: assert property (@(posedge link_clk_i) disable iff (link_rst) // RULE3
		(st_reg == ST_TX_ACK && ack_seen_reg && !mack_reg && scl_fall
			&& !stop_det && !start_det) |=> (st_reg == ST_IDLE && !sda_oe_o))
		else $error("data line kept after master nack");
	addr_miss_a: assert property (@(posedge link_clk_i) disable iff (link_rst) // RULE8
		(addr_last_bit_s and (rx_byte[7:1] != own_addr) && !stop_det && !start_det)
			|=> !ack_pend_reg)
		else $error("foreign address acknowledged");
	hs_enter_a: assert property (@(posedge link_clk_i) disable iff (link_rst) // RULE10
		(addr_last_bit_s and is_hs_code(rx_byte) && !stop_det && !start_det)
			|=> (hs_mode_reg && !ack_pend_reg))
		else $error("master code mishandled");
	hs_exit_a: assert property (@(posedge link_clk_i) disable iff (link_rst) // RULE12
		stop_det |=> !hs_mode_reg)
		else $error("high speed kept after stop");
	start_seen_a: assert property (@(posedge link_clk_i) disable iff (link_rst) // RULE21
		(start_det && !stop_det) |=> (st_reg == ST_RX_BIT && bit_cnt_reg == 4'h0 && !sda_oe_o))
		else $error("start not taken");
	stop_idle_a: assert property (@(posedge link_clk_i) disable iff (link_rst) // RULE22
		stop_det |=> (st_reg == ST_IDLE && !sda_oe_o))
		else $error("stop not taken");
	tx_shift_a: assert property (@(posedge link_clk_i) disable iff (link_rst) // RULE20
		(st_reg == ST_TX_BIT && scl_fall && bit_cnt_reg != 4'h8 && !stop_det && !start_det)
			|=> (sda_oe_o == ~$past(shift_reg[6])))
		else $error("wrong bit driven");
	res_load_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE19
		res_load_i |=> (resolution_o
			== $past({resolution_select_hi_i, resolution_select_lo_i})))
		else $error("resolution not loaded");
endmodule

// ### bus_master_model.sv
// Purpose: behavioural two-wire bus master facing the slave port
// Assumes: open-drain wire with pull-up; slave pulls low via sda_oe_i
// Notes:   clock stands high between frames; one bit takes four quarters
`timescale 1ns/10ps
module bus_master_model #(
	parameter int QTR_NS = 300
)(
	input  wire logic sda_oe_i,
	output logic      scl_o,
	output logic      sda_o
);
	logic pull_low;

	initial
	begin
		scl_o = 1'b1;
		pull_low = 1'b0;
	end

	// released wire floats to the pull-up level
	assign sda_o = ~(pull_low | sda_oe_i);

	// ============================================================
	// conditions
	// works as first start and as repeated start
	task automatic start_cond();
		pull_low = 1'b0;
		#QTR_NS;
		scl_o = 1'b1;
		#QTR_NS;
		pull_low = 1'b1;
		#QTR_NS;
		scl_o = 1'b0;
		#QTR_NS;
	endtask

	task automatic stop_cond();
		pull_low = 1'b1;
		#QTR_NS;
		scl_o = 1'b1;
		#QTR_NS;
		pull_low = 1'b0;
		#QTR_NS;
	endtask

	// ============================================================
	// bits and bytes
	// seen is high if the wire was high at either sample of the high phase
	task automatic clock_bit(input logic drive_low, output logic seen);
		logic first;
		pull_low = drive_low;
		#QTR_NS;
		scl_o = 1'b1;
		#(QTR_NS / 2);
		first = sda_o;
		#QTR_NS;
		seen = first | sda_o;
		#(QTR_NS / 2);
		scl_o = 1'b0;
		#QTR_NS;
	endtask

	task automatic write_byte(input logic [7:0] b, output logic ack);
		logic seen;
		for (int i = 7; i >= 0; i--)
			clock_bit(~b[i], seen);
		clock_bit(1'b0, seen);
		ack = ~seen;
	endtask

	task automatic read_byte(input logic last, output logic [7:0] b);
		logic seen;
		for (int i = 7; i >= 0; i--)
		begin
			clock_bit(1'b0, seen);
			b[i] = seen;
		end
		clock_bit(~last, seen);
		pull_low = 1'b0;
	endtask
endmodule

// ### temp_sensor_serial_slave_port_test.sv
// Purpose: self-checking bench of the temperature sensor slave port
// Assumes: bus master model drives the wire; short conversion base
// Notes:   a second port on the same wire runs as the strapless variant
`timescale 1ns/10ps
`define CHK(nm, e, g) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			num_errors++; \
			$display("ERROR %s expected %0h seen %0h", nm, e, g); \
		end \
	end
module temp_sensor_serial_slave_port_test;
	import temp_sensor_pkg::*;
	localparam int         CONV_BASE = 16;
	localparam logic [3:0] TYPE_ID   = 4'hA; // value arbitrary; msb must be 1
	localparam logic [2:0] STRAPS    = 3'h5;
	localparam logic [2:0] FIXED     = 3'h3; // differs from STRAPS and from ~STRAPS

	logic        core_clk = 1'b0;
	logic        link_clk = 1'b0;
	logic        rst      = 1'b1;
	logic        scl;
	logic        sda;
	logic        sda_oe;
	logic        sda_oe_fixed;
	logic        sda_pad;
	res_sel_t    res_sel  = 2'h3;
	logic        res_load = 1'b0;
	logic [11:0] code     = 12'hA5B;
	logic [15:0] result;
	logic        done;
	logic [1:0]  res_now;
	logic        hs;
	logic        ack;
	int          n;
	int          num_errors   = 0;
	int          total_checks = 0;

	always #4 core_clk = ~core_clk;

	// offset start keeps the link clock out of step with the core clock
	initial
	begin
		#3.3;
		forever #15 link_clk = ~link_clk;
	end

	temp_sensor_serial_slave_port #(
		.CONV_BASE_CYC(CONV_BASE),
		.TYPE_ID      (TYPE_ID)
	) u_temp_sensor_serial_slave_port (
		.core_clk_i            (core_clk),
		.rst_i                 (rst),
		.link_clk_i            (link_clk),
		.scl_i                 (scl),
		.sda_i                 (sda),
		.sda_o                 (sda_pad),
		.sda_oe_o              (sda_oe),
		.addr_strap_bit2_i     (STRAPS[2]),
		.addr_strap_bit1_i     (STRAPS[1]),
		.addr_strap_bit0_i     (STRAPS[0]),
		.resolution_select_hi_i(res_sel[1]),
		.resolution_select_lo_i(res_sel[0]),
		.res_load_i            (res_load),
		.sensor_code_i         (code),
		.temp_result_o         (result),
		.conv_done_o           (done),
		.resolution_o          (res_now),
		.hs_mode_o             (hs)
	);

	// strapless variant on the same wire; its strap pins must be ignored
	temp_sensor_serial_slave_port #(
		.CONV_BASE_CYC(CONV_BASE),
		.HAS_STRAPS   (1'b0),
		.FIXED_LOW    (FIXED),
		.TYPE_ID      (TYPE_ID)
	) u_temp_sensor_serial_slave_port_fixed (
		.core_clk_i            (core_clk),
		.rst_i                 (rst),
		.link_clk_i            (link_clk),
		.scl_i                 (scl),
		.sda_i                 (sda),
		.sda_o                 (),
		.sda_oe_o              (sda_oe_fixed),
		.addr_strap_bit2_i     (STRAPS[2]),
		.addr_strap_bit1_i     (STRAPS[1]),
		.addr_strap_bit0_i     (STRAPS[0]),
		.resolution_select_hi_i(res_sel[1]),
		.resolution_select_lo_i(res_sel[0]),
		.res_load_i            (res_load),
		.sensor_code_i         (code),
		.temp_result_o         (),
		.conv_done_o           (),
		.resolution_o          (),
		.hs_mode_o             ()
	);

	bus_master_model u_bus_master_model (
		.sda_oe_i(sda_oe | sda_oe_fixed),
		.scl_o   (scl),
		.sda_o   (sda)
	);

	// ============================================================
	// tasks
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic wait_done(output int cnt);
		cnt = 0;
		do
		begin
			@(posedge core_clk);
			#1;
			cnt++;
		end
		while (done !== 1'b1 && cnt < 5000);
		if (done !== 1'b1)
		begin
			`CHK("conv done", 1'b1, done);
			give_verdict();
		end
	endtask

	task automatic wait_hs(input logic v);
		for (int i = 0; i < 300 && hs !== v; i++)
			@(posedge core_clk);
		`CHK("hs mode", v, hs);
		if (hs !== v)
			give_verdict();
	endtask

	task automatic set_res(input res_sel_t r);
		@(posedge core_clk);
		res_sel <= r;
		res_load <= 1'b1;
		@(posedge core_clk);
		res_load <= 1'b0;
		@(posedge core_clk);
		#1;
		`CHK("resolution", r, res_now);
	endtask

	task automatic send_addr(input logic rd, input logic [2:0] low, input logic exp);
		u_bus_master_model.start_cond();
		u_bus_master_model.write_byte({TYPE_ID, low, rd}, ack);
		`CHK("address ack", exp, ack);
	endtask

	task automatic read_temp(input logic [15:0] e, input logic hs_exp);
		logic [7:0] hi;
		logic [7:0] lo;
		send_addr(1'b1, STRAPS, 1'b1);
		u_bus_master_model.read_byte(1'b0, hi);
		u_bus_master_model.read_byte(1'b1, lo);
		`CHK("release after nack", 1'b0, sda_oe);
		`CHK("hs held", hs_exp, hs);
		u_bus_master_model.stop_cond();
		`CHK("temperature", e, {hi, lo});
	endtask

	// ============================================================
	// main sequence
	initial
	begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		repeat (100) @(posedge core_clk);
		#1;
		`CHK("reset resolution", 2'h0, res_now);
		`CHK("reset hs", 1'b0, hs);
		`CHK("reset oe", 1'b0, sda_oe);
		`CHK("pad level", 1'b0, sda_pad);
		// leading one bit keeps this byte from forming a start
		u_bus_master_model.write_byte({TYPE_ID, STRAPS, 1'b0}, ack);
		`CHK("no start ack", 1'b0, ack);
		u_bus_master_model.stop_cond();
		send_addr(1'b0, ~STRAPS, 1'b0);
		u_bus_master_model.write_byte(8'h00, ack);
		`CHK("idle after mismatch", 1'b0, ack);
		u_bus_master_model.stop_cond();
		send_addr(1'b0, STRAPS, 1'b1);
		u_bus_master_model.write_byte(8'h00, ack);
		`CHK("pointer ack", 1'b1, ack);
		u_bus_master_model.write_byte(8'h5A, ack);
		`CHK("read-only nack", 1'b0, ack);
		u_bus_master_model.stop_cond();
		send_addr(1'b0, STRAPS, 1'b1);
		u_bus_master_model.write_byte(8'h01, ack);
		`CHK("bad pointer nack", 1'b0, ack);
		u_bus_master_model.stop_cond();
		send_addr(1'b0, FIXED, 1'b1);
		u_bus_master_model.stop_cond();
		for (int r = 0; r < 4; r++)
		begin
			set_res(r[1:0]);
			wait_done(n);
			wait_done(n);
			wait_done(n);
			`CHK("conv period", CONV_BASE << r, n);
			`CHK("result", {code & (12'hFFF << (3 - r)), 4'h0}, result);
		end
		@(posedge core_clk);
		code <= 12'h800;
		wait_done(n);
		wait_done(n);
		read_temp(16'h8000, 1'b0);
		@(posedge core_clk);
		code <= 12'h7FF;
		wait_done(n);
		wait_done(n);
		u_bus_master_model.start_cond();
		u_bus_master_model.write_byte(8'h0D, ack);
		`CHK("master code nack", 1'b0, ack);
		wait_hs(1'b1);
		read_temp(16'h7FF0, 1'b1);
		wait_hs(1'b0);
		give_verdict();
	end
endmodule
